// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import rmgr_pkg::*;
;
  localparam int WD = 20;
  localparam int XC = 8;

  logic mclk_i, rstn_i, ce_i, ext_reset_low_i, pads_ok_i, regulator_ok_i;
  logic rc_clk_i, xtal_edge_i, wdog_restart_i, pc_rollover_i, sw_reset_i;
  logic sleep_req_i, irq_i, wake_ext_i;
  logic [CAL_DIV_W-1:0] cal_div_i;
  rmgr_mode_t sleep_mode_i;
  logic [SLEEP_W-1:0] wake_at_i;
  logic aon_rstn_o, core_rstn_o, cpu_halt_o, regulator_en_o;
  logic core_pwr_en_o, radio_pwr_en_o, out_freeze_o;
  rmgr_mode_t mode_o;
  rmgr_cause_t reset_cause_o;
  logic [SLEEP_W-1:0] sleep_count_o;
  logic [11:0] st;
  logic [15:0] c0;
  int mismatches;
  int n_checks;

  // Cause above the control word, same bit order as the package constants
  assign st = {reset_cause_o, mode_o, out_freeze_o, radio_pwr_en_o,
               core_pwr_en_o, regulator_en_o, cpu_halt_o, core_rstn_o,
               aon_rstn_o};

  rmgr_top #(.WDOG_TIMEOUT(WD), .XTAL_COUNT(XC), .PRESC_N(0)) uut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .ext_reset_low_i(ext_reset_low_i), .pads_ok_i(pads_ok_i),
    .regulator_ok_i(regulator_ok_i), .rc_clk_i(rc_clk_i),
    .xtal_edge_i(xtal_edge_i), .wdog_restart_i(wdog_restart_i),
    .pc_rollover_i(pc_rollover_i), .sw_reset_i(sw_reset_i),
    .cal_div_i(cal_div_i), .sleep_req_i(sleep_req_i),
    .sleep_mode_i(sleep_mode_i), .wake_at_i(wake_at_i), .irq_i(irq_i),
    .wake_ext_i(wake_ext_i), .aon_rstn_o(aon_rstn_o),
    .core_rstn_o(core_rstn_o), .cpu_halt_o(cpu_halt_o),
    .regulator_en_o(regulator_en_o), .core_pwr_en_o(core_pwr_en_o),
    .radio_pwr_en_o(radio_pwr_en_o), .out_freeze_o(out_freeze_o),
    .mode_o(mode_o), .reset_cause_o(reset_cause_o),
    .sleep_count_o(sleep_count_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Inputs always move 10 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      #10;
    end
  endtask

  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic wait_st(input logic [11:0] mask, input logic [11:0] exp);
    int i;
    i = 0;
    while (((st & mask) !== exp) && i < 300) begin
      cyc(1);
      i++;
    end
    check(16'(exp), 16'(st & mask));
    if (i >= 300) end_sim();
  endtask

  // RC high for two cycles so a slow sampler still sees each rise
  task automatic rc_pulse(input int n);
    repeat (n) begin
      rc_clk_i = 1'b1;
      cyc(2);
      rc_clk_i = 1'b0;
      cyc(2);
    end
  endtask

  task automatic core_up();
    regulator_ok_i = 1'b1;
    cyc(2);
    repeat (XC - 1) begin
      xtal_edge_i = 1'b1;
      cyc(1);
      xtal_edge_i = 1'b0;
      cyc(1);
    end
    cyc(2);
    check(16'h0, 16'(core_rstn_o));
    xtal_edge_i = 1'b1;
    cyc(1);
    xtal_edge_i = 1'b0;
    wait_st(12'h1FF, {3'h0, CTL_ACT});
  endtask

  task automatic boot();
    regulator_ok_i = 1'b0;
    pads_ok_i = 1'b1;
    rc_pulse(2);
    cyc(2);
    check(16'h0, 16'(aon_rstn_o));
    rc_pulse(1);
    wait_st(12'h003, 12'h001);
    cyc(6);
    check(16'h0, 16'(core_rstn_o));
    core_up();
  endtask

  task automatic sleep_enter(input rmgr_mode_t m);
    sleep_mode_i = m;
    sleep_req_i = 1'b1;
    cyc(1);
    sleep_req_i = 1'b0;
  endtask

  task automatic sleep_cycle(input rmgr_mode_t m, input bit tw);
    logic [8:0] ctl;
    ctl = (m == PM_DEEP) ? CTL_DEEP : CTL_PDOWN;
    sleep_enter(m);
    wait_st(12'h1FF, {3'h0, ctl});
    regulator_ok_i = 1'b0;
    // Power down also gets a near timer match, which must not wake it
    wake_at_i = sleep_count_o + ((tw || m == PM_PDOWN) ? 16'h0002 : 16'h0100);
    rc_pulse(6);
    if (!tw) begin
      check(16'(ctl), 16'(st[8:0]));
      wake_ext_i = 1'b1;
      cyc(1);
      wake_ext_i = 1'b0;
    end
    wait_st(12'h1FF, {3'h0, CTL_WAKE});
    cyc(3);
    // Core must stay dark until the regulator reports good
    check(16'(CTL_WAKE), 16'(st[8:0]));
    regulator_ok_i = 1'b1;
    wait_st(12'h1FF, {3'h0, CTL_ACT});
  endtask

  initial begin
    rstn_i = 1'b0;
    ce_i = 1'b1;
    ext_reset_low_i = 1'b1;
    pads_ok_i = 1'b0;
    regulator_ok_i = 1'b0;
    rc_clk_i = 1'b0;
    xtal_edge_i = 1'b0;
    wdog_restart_i = 1'b1;
    pc_rollover_i = 1'b0;
    sw_reset_i = 1'b0;
    cal_div_i = 8'h02;
    sleep_req_i = 1'b0;
    sleep_mode_i = PM_ACTIVE;
    wake_at_i = 16'hFFFF;
    irq_i = 1'b0;
    wake_ext_i = 1'b0;
    mismatches = 0;
    n_checks = 0;
    cyc(5);
    check(16'({3'h1, CTL_RESET}), 16'(st));
    rstn_i = 1'b1;
    rc_pulse(4);
    check(16'h0, 16'(aon_rstn_o));
    boot();
    $display("test boot done");

    c0 = sleep_count_o;
    rc_pulse(4);
    cyc(2);
    check(c0 + 16'h0002, sleep_count_o);
    // Clock enable low freezes the timer and its divider
    ce_i = 1'b0;
    rc_pulse(4);
    check(c0 + 16'h0002, sleep_count_o);
    ce_i = 1'b1;
    $display("test sleep timer done");

    sleep_enter(PM_ACTIVE);
    cyc(3);
    check(16'({3'h1, CTL_ACT}), 16'(st));
    sleep_enter(PM_IDLE);
    wait_st(12'h1FF, {3'h0, CTL_IDL});
    cyc(4);
    check(16'(CTL_IDL), 16'(st[8:0]));
    irq_i = 1'b1;
    cyc(1);
    irq_i = 1'b0;
    wait_st(12'h1FF, {3'h0, CTL_ACT});
    $display("test idle done");

    sleep_cycle(PM_PDOWN, 1'b0);
    sleep_cycle(PM_DEEP, 1'b1);
    sleep_cycle(PM_DEEP, 1'b0);
    $display("test sleep modes done");

    for (int k = 0; k < 3; k++) begin
      case (k)
        0: pc_rollover_i = 1'b1;
        1: sw_reset_i = 1'b1;
        default: regulator_ok_i = 1'b0;
      endcase
      cyc(1);
      pc_rollover_i = 1'b0;
      sw_reset_i = 1'b0;
      wait_st(12'hE02, {3'(k + 3), 9'h000});
      core_up();
    end
    $display("test reset causes done");

    ext_reset_low_i = 1'b0;
    cyc(2);
    ext_reset_low_i = 1'b1;
    cyc(4);
    check(16'({3'h5, CTL_ACT}), 16'(st));
    ext_reset_low_i = 1'b0;
    cyc(5);
    ext_reset_low_i = 1'b1;
    wait_st(12'hFFF, {3'h1, CTL_RESET});
    boot();
    $display("test pin reset done");

    wdog_restart_i = 1'b0;
    rc_pulse(WD - 1);
    check(16'h1, 16'(aon_rstn_o));
    wdog_restart_i = 1'b1;
    cyc(1);
    wdog_restart_i = 1'b0;
    rc_pulse(WD - 1);
    check(16'h1, 16'(aon_rstn_o));
    rc_pulse(1);
    wait_st(12'hE01, {3'h2, 9'h000});
    boot();
    wdog_restart_i = 1'b1;
    $display("test watchdog done");

    rstn_i = 1'b0;
    cyc(2);
    check(16'({3'h1, CTL_RESET}), 16'(st));
    $display("test second reset done");
    end_sim();
  end
endmodule

// file: core/rmgr_cnt_if.sv
`timescale 1ns/1ps
interface rmgr_cnt_if #(parameter int W = 4) ();
  logic ce;
  logic clr;
  logic step;
  logic [W-1:0] target;
  logic [W-1:0] count;
  logic done;
  modport ctrl (output ce, clr, step, target, input count, done);
  modport cnt (input ce, clr, step, target, output count, done);
endinterface

// file: core/rmgr_counter.sv
`timescale 1ns/1ps
module rmgr_counter #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Control and result
  rmgr_cnt_if.cnt c
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // A step in the clearing cycle is kept, not lost
  always_comb begin
    count_next = count_reg;
    if (c.clr) begin
      count_next = c.step ? W'(1) : '0;
    end else if (c.step && !c.done) begin
      count_next = count_reg + W'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= '0;
    end else if (c.ce) begin
      count_reg <= count_next;
    end
  end

  assign c.count = count_reg;
  assign c.done = (count_reg == c.target);

  property p_cnt_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
    c.ce && c.done && !c.clr |=> c.done;
  endproperty
  a_cnt_hold: assert property (p_cnt_hold)
    else $error("counter left its target without a clear");

endmodule

// file: core/rmgr_pkg.sv
package rmgr_pkg;

  // Reset pin filter
  localparam int CLK_NS = 100;
  localparam int EXT_RST_NS = 200;
  localparam int EXT_RST_CYC = (EXT_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] EXT_RST_TRIP = 3'(EXT_RST_CYC + 1);

  // Power-on sequencing
  localparam int RC_PULSE_W = 2;
  localparam logic [1:0] RC_PULSES = 2'h3;
  localparam int XTAL_EDGES = 1024;

  // Oscillator and timers
  localparam int RC_HZ = 10000;
  localparam int CAL_HZ = 1000;
  localparam int CAL_DIV_W = 8;
  localparam logic [7:0] CAL_DIV_RST = 8'(RC_HZ / CAL_HZ);
  localparam int WDOG_MS = 2000;
  localparam int WDOG_RC_EDGES = WDOG_MS * (RC_HZ / 1000);
  localparam int TICK_MS = 1;
  localparam int PRESC_LOG2 = $clog2(CAL_HZ * TICK_MS / 1000);
  localparam int PRESC_W = 8;
  localparam int SLEEP_W = 16;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'h0,
    PM_IDLE   = 2'h1,
    PM_DEEP   = 2'h2,
    PM_PDOWN  = 2'h3
  } rmgr_mode_t;

  typedef enum logic [2:0] {
    ST_AON_RST  = 3'h0,
    ST_CORE_RST = 3'h1,
    ST_XTAL     = 3'h2,
    ST_ACTIVE   = 3'h3,
    ST_IDLE     = 3'h4,
    ST_DEEP     = 3'h5,
    ST_PDOWN    = 3'h6,
    ST_WAKE     = 3'h7
  } rmgr_state_t;

  typedef enum logic [2:0] {
    CAUSE_POR  = 3'h1,
    CAUSE_WDOG = 3'h2,
    CAUSE_PC   = 3'h3,
    CAUSE_SOFT = 3'h4,
    CAUSE_DIP  = 3'h5
  } rmgr_cause_t;

  // Control word: field positions
  localparam int CTL_W = 9;
  localparam int CTL_AON_RUN = 0;
  localparam int CTL_CORE_RUN = 1;
  localparam int CTL_HALT = 2;
  localparam int CTL_REG_EN = 3;
  localparam int CTL_CORE_PWR = 4;
  localparam int CTL_RADIO_PWR = 5;
  localparam int CTL_FREEZE = 6;
  localparam int CTL_MODE = 7;

  // Control word per state
  localparam logic [8:0] CTL_RESET = 9'h03C;
  localparam logic [8:0] CTL_CORE_HOLD = 9'h03D;
  localparam logic [8:0] CTL_ACT = 9'h03B;
  localparam logic [8:0] CTL_IDL = 9'h0BF;
  localparam logic [8:0] CTL_DEEP = 9'h147;
  localparam logic [8:0] CTL_PDOWN = 9'h1C7;
  localparam logic [8:0] CTL_WAKE = 9'h04F;

endpackage

// file: core/rmgr_top.sv
// How it works
// - Reset pin held low over 200 ns puts the device in reset.
// - Short low glitches on the reset pin are filtered out.
// - While the pin reset is active all state returns to reset values.
// - Cause of the last reset is kept in a readable cause output.
// - Always-on domain stays reset until pads good and three RC pulses.
// - Core held in reset while regulator output is below threshold, except in sleep and wake, where core power is off instead.
// - Core reset released only after 1024 crystal edges are counted.
// - Raw RC oscillator runs always and paces the management logic.
// - Programmable divider makes about 1 kHz from RC for the sleep timer.
// - Watchdog on RC clock resets the whole device after about 2 s.
// - Watchdog reset stays internal and drives no pin.
// - Only firmware can restart the watchdog; no host control exists.
// - 16-bit sleep timer ticks every 1 ms via power-of-two prescaler.
// - Exactly four power modes: active, idle, deep sleep, power down.
// - Idle halts the CPU until any interrupt; everything else runs.
// - Sleep modes power off core and radio, regulator off, outputs frozen.
// - Waking from sleep re-enables the regulator before core resumes.
// - Deep sleep wakes on timer or external; power down only external.
`timescale 1ns/1ps
module rmgr_top
  import rmgr_pkg::*;
#(
  parameter int WDOG_TIMEOUT = WDOG_RC_EDGES,
  parameter int XTAL_COUNT = XTAL_EDGES,
  parameter int PRESC_N = PRESC_LOG2
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Pins and supply monitors
  input wire logic ext_reset_low_i,
  input wire logic pads_ok_i,
  input wire logic regulator_ok_i,
  input wire logic rc_clk_i,
  input wire logic xtal_edge_i,
  // Firmware controls
  input wire logic wdog_restart_i,
  input wire logic pc_rollover_i,
  input wire logic sw_reset_i,
  input wire logic [CAL_DIV_W-1:0] cal_div_i,
  input wire logic sleep_req_i,
  input wire rmgr_mode_t sleep_mode_i,
  input wire logic [SLEEP_W-1:0] wake_at_i,
  // Wake sources
  input wire logic irq_i,
  input wire logic wake_ext_i,
  // Domain controls
  output logic aon_rstn_o,
  output logic core_rstn_o,
  output logic cpu_halt_o,
  output logic regulator_en_o,
  output logic core_pwr_en_o,
  output logic radio_pwr_en_o,
  output logic out_freeze_o,
  // Status
  output rmgr_mode_t mode_o,
  output rmgr_cause_t reset_cause_o,
  output logic [SLEEP_W-1:0] sleep_count_o
);

  localparam int WDOG_W = $clog2(WDOG_TIMEOUT + 1);
  localparam int XTAL_W = $clog2(XTAL_COUNT + 1);

  // Pin filter and RC edge
  logic [2:0] low_cnt_reg;
  logic [2:0] low_cnt_next;
  logic rc_q_reg;
  logic ext_rst_act;
  logic rc_rise;

  always_comb begin
    low_cnt_next = low_cnt_reg;
    if (ext_reset_low_i) begin
      low_cnt_next = 3'h0;
    end else if (low_cnt_reg != EXT_RST_TRIP) begin
      low_cnt_next = low_cnt_reg + 3'h1;
    end
  end

  assign ext_rst_act = (low_cnt_reg == EXT_RST_TRIP);
  assign rc_rise = rc_clk_i && !rc_q_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt_reg <= 3'h0;
      rc_q_reg <= 1'b0;
    end else if (ce_i) begin
      low_cnt_reg <= low_cnt_next;
      rc_q_reg <= rc_clk_i;
    end
  end

  // Counters
  rmgr_state_t state_reg;
  rmgr_state_t state_next;
  logic run;

  assign run = (state_reg == ST_ACTIVE) || (state_reg == ST_IDLE);

  rmgr_cnt_if #(.W(RC_PULSE_W)) rc3_if ();
  rmgr_cnt_if #(.W(XTAL_W)) xtal_if ();
  rmgr_cnt_if #(.W(WDOG_W)) wdog_if ();
  rmgr_cnt_if #(.W(CAL_DIV_W)) cal_if ();

  assign rc3_if.ce = ce_i;
  // Pulses seen before the pad supply is good must not count
  assign rc3_if.clr = (state_reg != ST_AON_RST) || ext_rst_act || !pads_ok_i;
  assign rc3_if.step = rc_rise;
  assign rc3_if.target = RC_PULSES;

  assign xtal_if.ce = ce_i;
  assign xtal_if.clr = (state_reg != ST_XTAL);
  assign xtal_if.step = xtal_edge_i;
  assign xtal_if.target = XTAL_W'(XTAL_COUNT);

  // Restart comes only from the firmware port; nothing host-side reaches it
  assign wdog_if.ce = ce_i;
  assign wdog_if.clr = wdog_restart_i || !run;
  assign wdog_if.step = rc_rise;
  assign wdog_if.target = WDOG_W'(WDOG_TIMEOUT);

  // Divider restarts itself on reaching the programmed ratio
  assign cal_if.ce = ce_i;
  assign cal_if.clr = cal_if.done || ext_rst_act;
  assign cal_if.step = rc_rise;
  assign cal_if.target = cal_div_i;

  rmgr_counter #(.W(RC_PULSE_W)) u_rc3 (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .c(rc3_if)
  );
  rmgr_counter #(.W(XTAL_W)) u_xtal (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .c(xtal_if)
  );
  rmgr_counter #(.W(WDOG_W)) u_wdog (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .c(wdog_if)
  );
  rmgr_counter #(.W(CAL_DIV_W)) u_cal (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .c(cal_if)
  );

  // Sleep timer
  localparam logic [PRESC_W-1:0] PRESC_MASK = PRESC_W'((1 << PRESC_N) - 1);
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_next;
  logic [SLEEP_W-1:0] sleep_reg;
  logic [SLEEP_W-1:0] sleep_next;
  logic ms_tick;
  logic timer_hit;

  assign ms_tick = cal_if.done && ((presc_reg & PRESC_MASK) == PRESC_MASK);
  assign timer_hit = ms_tick && ((sleep_reg + 16'h0001) == wake_at_i);

  always_comb begin
    presc_next = presc_reg;
    sleep_next = sleep_reg;
    if (ext_rst_act) begin
      presc_next = '0;
      sleep_next = '0;
    end else begin
      if (cal_if.done) begin
        presc_next = presc_reg + PRESC_W'(1);
      end
      if (ms_tick) begin
        // Free-running wrap; long delays are extended by firmware
        sleep_next = sleep_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      presc_reg <= '0;
      sleep_reg <= '0;
    end else if (ce_i) begin
      presc_reg <= presc_next;
      sleep_reg <= sleep_next;
    end
  end

  assign sleep_count_o = sleep_reg;

  // Sequencer and power modes
  rmgr_cause_t cause_reg;
  rmgr_cause_t cause_next;
  logic [CTL_W-1:0] ctl_reg;
  logic [CTL_W-1:0] ctl_next;

  function automatic logic [CTL_W-1:0] ctl_f(input rmgr_state_t s);
    logic [CTL_W-1:0] c;
    c = CTL_RESET;
    case (s)
      ST_AON_RST: c = CTL_RESET;
      ST_CORE_RST: c = CTL_CORE_HOLD;
      ST_XTAL: c = CTL_CORE_HOLD;
      ST_ACTIVE: c = CTL_ACT;
      ST_IDLE: c = CTL_IDL;
      ST_DEEP: c = CTL_DEEP;
      ST_PDOWN: c = CTL_PDOWN;
      ST_WAKE: c = CTL_WAKE;
      default: c = CTL_RESET;
    endcase
    return c;
  endfunction

  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    if (ext_rst_act || !pads_ok_i) begin
      state_next = ST_AON_RST;
      cause_next = CAUSE_POR;
    end else if (run && wdog_if.done) begin
      // Acts on the domain controls only, never on a pin
      state_next = ST_AON_RST;
      cause_next = CAUSE_WDOG;
    end else if (run && pc_rollover_i) begin
      state_next = ST_CORE_RST;
      cause_next = CAUSE_PC;
    end else if (run && sw_reset_i) begin
      state_next = ST_CORE_RST;
      cause_next = CAUSE_SOFT;
    end else if (run && !regulator_ok_i) begin
      state_next = ST_CORE_RST;
      cause_next = CAUSE_DIP;
    end else begin
      case (state_reg)
        ST_AON_RST: begin
          if (rc3_if.done) begin
            state_next = ST_CORE_RST;
          end
        end
        ST_CORE_RST: begin
          if (regulator_ok_i) begin
            state_next = ST_XTAL;
          end
        end
        ST_XTAL: begin
          if (!regulator_ok_i) begin
            state_next = ST_CORE_RST;
          end else if (xtal_if.done) begin
            state_next = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (sleep_req_i) begin
            case (sleep_mode_i)
              PM_IDLE: state_next = ST_IDLE;
              PM_DEEP: state_next = ST_DEEP;
              PM_PDOWN: state_next = ST_PDOWN;
              default: state_next = ST_ACTIVE;
            endcase
          end
        end
        ST_IDLE: begin
          if (irq_i) begin
            state_next = ST_ACTIVE;
          end
        end
        ST_DEEP: begin
          if (wake_ext_i || timer_hit) begin
            state_next = ST_WAKE;
          end
        end
        ST_PDOWN: begin
          if (wake_ext_i) begin
            state_next = ST_WAKE;
          end
        end
        ST_WAKE: begin
          // Core stays unpowered until the regulator is back up
          if (regulator_ok_i) begin
            state_next = ST_ACTIVE;
          end
        end
        default: state_next = ST_AON_RST;
      endcase
    end
    ctl_next = ctl_f(state_next);
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_AON_RST;
      cause_reg <= CAUSE_POR;
      ctl_reg <= CTL_RESET;
    end else if (ce_i) begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      ctl_reg <= ctl_next;
    end
  end

  assign aon_rstn_o = ctl_reg[CTL_AON_RUN];
  assign core_rstn_o = ctl_reg[CTL_CORE_RUN];
  assign cpu_halt_o = ctl_reg[CTL_HALT];
  assign regulator_en_o = ctl_reg[CTL_REG_EN];
  assign core_pwr_en_o = ctl_reg[CTL_CORE_PWR];
  assign radio_pwr_en_o = ctl_reg[CTL_RADIO_PWR];
  assign out_freeze_o = ctl_reg[CTL_FREEZE];
  assign mode_o = rmgr_mode_t'(ctl_reg[CTL_MODE +: 2]);
  assign reset_cause_o = cause_reg;

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_pin_rst;
    (!ext_reset_low_i && ce_i) [*3] ##1 ce_i |=> state_reg == ST_AON_RST;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("held reset pin did not reset the device");

  property p_glitch;
    ce_i && ext_reset_low_i |=> !ext_rst_act;
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("reset filter active after pin went high");

  property p_pin_clear;
    ce_i && ext_rst_act |=> sleep_reg == '0 && !aon_rstn_o && !core_rstn_o;
  endproperty
  a_pin_clear: assert property (p_pin_clear)
    else $error("state not cleared under pin reset");

  property p_cause_soft;
    ce_i && run && sw_reset_i && !pc_rollover_i && !wdog_if.done
      && !ext_rst_act && pads_ok_i |=> reset_cause_o == CAUSE_SOFT;
  endproperty
  a_cause_soft: assert property (p_cause_soft)
    else $error("software reset cause not recorded");

  property p_aon_rel;
    $rose(aon_rstn_o) |-> $past(pads_ok_i) && $past(rc3_if.done);
  endproperty
  a_aon_rel: assert property (p_aon_rel)
    else $error("always-on reset released too early");

  property p_core_dip;
    ce_i && run && !regulator_ok_i |=> !core_rstn_o;
  endproperty
  a_core_dip: assert property (p_core_dip)
    else $error("core not reset on supply dip");

  property p_xtal_rel;
    $rose(core_rstn_o) |-> $past(xtal_if.done) && $past(state_reg) == ST_XTAL;
  endproperty
  a_xtal_rel: assert property (p_xtal_rel)
    else $error("core released before crystal count");

  property p_wdog;
    ce_i && run && wdog_if.done && !ext_rst_act && pads_ok_i
      |=> !aon_rstn_o && !core_rstn_o ##0 reset_cause_o == CAUSE_WDOG;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog expiry did not reset device");

  property p_wdog_restart;
    ce_i && wdog_restart_i && !rc_rise |=> wdog_if.count == '0;
  endproperty
  a_wdog_restart: assert property (p_wdog_restart)
    else $error("watchdog restart ignored");

  property p_tick;
    ce_i && ms_tick && !ext_rst_act
      |=> sleep_count_o == $past(sleep_count_o) + 16'h0001;
  endproperty
  a_tick: assert property (p_tick)
    else $error("sleep timer did not advance on tick");

  property p_idle_exit;
    ce_i && state_reg == ST_IDLE && irq_i && !ext_rst_act && pads_ok_i
      && regulator_ok_i && !wdog_if.done && !pc_rollover_i && !sw_reset_i
      |=> !cpu_halt_o && radio_pwr_en_o && mode_o == PM_ACTIVE;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("interrupt did not end idle");

  property p_sleep_off;
    (state_reg == ST_DEEP || state_reg == ST_PDOWN)
      |-> !regulator_en_o && out_freeze_o && !radio_pwr_en_o && !core_pwr_en_o;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("sleep mode left power or outputs live");

  property p_wake_reg;
    $fell(out_freeze_o) && state_reg == ST_ACTIVE
      |-> $past(regulator_en_o) && $past(state_reg) == ST_WAKE;
  endproperty
  a_wake_reg: assert property (p_wake_reg)
    else $error("core resumed without regulator enabled");

  property p_pdown_hold;
    ce_i && state_reg == ST_PDOWN && !wake_ext_i && !ext_rst_act && pads_ok_i
      |=> state_reg == ST_PDOWN;
  endproperty
  a_pdown_hold: assert property (p_pdown_hold)
    else $error("power down woke without external signal");

  c_boot: cover property ($past(state_reg) == ST_XTAL && state_reg == ST_ACTIVE);
  c_timer_wake: cover property (state_reg == ST_DEEP && timer_hit && ce_i);
  c_idle_exit: cover property ($past(state_reg) == ST_IDLE
    && state_reg == ST_ACTIVE);
  c_wdog: cover property (reset_cause_o == CAUSE_WDOG);

endmodule
